// *** aspr_pkg.sv ***
// package: constants, types and register layout for the serial port
package aspr_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ASPR_CTRL_ADDR   = 8'h98;
  localparam logic [7:0] ASPR_DATA_ADDR   = 8'h99;
  localparam logic [7:0] ASPR_CTRL_RESET  = 8'h40;
  localparam int         ASPR_BIT_MODE    = 7;
  localparam int         ASPR_BIT_UNUSED  = 6;
  localparam int         ASPR_BIT_MCE     = 5;
  localparam int         ASPR_BIT_REN     = 4;
  localparam int         ASPR_BIT_TB8     = 3;
  localparam int         ASPR_BIT_RB8     = 2;
  localparam int         ASPR_BIT_TI      = 1;
  localparam int         ASPR_BIT_RI      = 0;
  // ---------------------------------------------------------------
  // frame timing
  // ---------------------------------------------------------------
  localparam logic [3:0] ASPR_BITS_8      = 4'h8;
  localparam logic [3:0] ASPR_BITS_9      = 4'h9;
  localparam logic [1:0] ASPR_SYNC_INIT   = 2'h3;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ASPR_IDLE  = 2'b00,
    ASPR_START = 2'b01,
    ASPR_DATA  = 2'b10,
    ASPR_STOP  = 2'b11
  } aspr_state_t;

  typedef struct packed {
    logic       mode;
    logic       mce;
    logic       ren;
    logic       tb8;
    logic       rb8;
    logic       ti;
    logic       ri;
  } aspr_ctrl_t;
endpackage : aspr_pkg

// *** aspr_uart.sv ***
// serial port with auto-reload baud timer, register port and serial lines
module aspr_uart
  import aspr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       timer_run,
  input  wire logic       timer_tick,
  input  wire logic [7:0] baud_reload_byte,
  input  wire logic       irq_enable,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            irq_req,
  output logic            tx_line,
  output logic      [7:0] baud_low_counter,
  input  wire logic       rx_line
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  aspr_ctrl_t  ctrl_r, ctrl_nxt;
  logic [7:0]  rx_buf_r, rx_buf_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        irq_r, irq_nxt;
  logic [7:0]  tx_cnt_r, tx_cnt_nxt;
  logic [7:0]  rx_cnt_r, rx_cnt_nxt;
  logic        tx_half_r, tx_half_nxt;
  logic        rx_half_r, rx_half_nxt;
  aspr_state_t tx_st_r, tx_st_nxt;
  logic [8:0]  tx_sh_r, tx_sh_nxt;
  logic [3:0]  tx_idx_r, tx_idx_nxt;
  logic        tx_line_r, tx_line_nxt;
  aspr_state_t rx_st_r, rx_st_nxt;
  logic [8:0]  rx_sh_r, rx_sh_nxt;
  logic [3:0]  rx_idx_r, rx_idx_nxt;
  logic [1:0]  rx_sync_r, rx_sync_nxt;
  logic        rx_prev_r, rx_prev_nxt;
  logic        tx_ovf, rx_ovf, tx_baud, rx_baud, rx_mid;
  logic        rx_fall, wr_ctrl, wr_data, rx_load;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // counter step with auto reload
  function automatic logic [7:0] aspr_step(input logic [7:0] cnt,
                                           input logic [7:0] rld);
    aspr_step = (cnt == 8'hFF) ? rld : cnt + 8'h01;
  endfunction : aspr_step

  // mode selects length
  // data bits per frame from the mode bit
  function automatic logic [3:0] aspr_nbits(input logic mode);
    aspr_nbits = mode ? ASPR_BITS_9 : ASPR_BITS_8;
  endfunction : aspr_nbits

  // ---------------------------------------------------------------
  // register access decode
  // ---------------------------------------------------------------
  assign wr_ctrl = reg_wr && (reg_addr == ASPR_CTRL_ADDR);
  assign wr_data = reg_wr && (reg_addr == ASPR_DATA_ADDR);
  // synchronised receive line; edge seen on the second stage only
  assign rx_fall = rx_prev_r && !rx_sync_r[1];

  // ---------------------------------------------------------------
  // baud timers
  // ---------------------------------------------------------------
  // overflow period
  assign tx_ovf  = timer_run && timer_tick && (tx_cnt_r == 8'hFF);
  assign rx_ovf  = timer_run && timer_tick && (rx_cnt_r == 8'hFF);
  assign tx_baud = tx_ovf && tx_half_r;
  assign rx_baud = rx_ovf && rx_half_r;
  assign rx_mid  = rx_ovf && !rx_half_r;

  // next counter and half-period values for both timers
  always_comb begin
    tx_cnt_nxt  = tx_cnt_r;
    rx_cnt_nxt  = rx_cnt_r;
    tx_half_nxt = tx_half_r;
    rx_half_nxt = rx_half_r;
    if (timer_run && timer_tick) begin
      tx_cnt_nxt = aspr_step(tx_cnt_r, baud_reload_byte);
      rx_cnt_nxt = aspr_step(rx_cnt_r, baud_reload_byte);
    end
    if (tx_ovf) begin
      tx_half_nxt = !tx_half_r;
    end
    if (rx_ovf) begin
      rx_half_nxt = !rx_half_r;
    end
    // forced reload
    // restarting the copy aligns its half-period phase to the start edge
    if (rx_st_r == ASPR_IDLE && rx_fall) begin
      rx_cnt_nxt  = baud_reload_byte;
      rx_half_nxt = 1'b0;
    end
  end

  // baud timer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_cnt_r  <= 8'h00;
      rx_cnt_r  <= 8'h00;
      tx_half_r <= 1'b0;
      rx_half_r <= 1'b0;
    end else begin
      tx_cnt_r  <= tx_cnt_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      tx_half_r <= tx_half_nxt;
      rx_half_r <= rx_half_nxt;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  // transmit sequencer: start, data bits, stop
  always_comb begin
    tx_st_nxt   = tx_st_r;
    tx_sh_nxt   = tx_sh_r;
    tx_idx_nxt  = tx_idx_r;
    tx_line_nxt = tx_line_r;
    case (tx_st_r)
      ASPR_IDLE: begin
        tx_line_nxt = 1'b1;
        if (wr_data) begin
          tx_sh_nxt = {ctrl_r.tb8, reg_wdata};
          tx_st_nxt = ASPR_START;
        end
      end
      ASPR_START: begin
        if (tx_baud) begin
          tx_line_nxt = 1'b0;
          tx_idx_nxt  = 4'h0;
          tx_st_nxt   = ASPR_DATA;
        end
      end
      ASPR_DATA: begin
        if (tx_baud) begin
          if (tx_idx_r == aspr_nbits(ctrl_r.mode)) begin
            tx_line_nxt = 1'b1;
            tx_st_nxt   = ASPR_STOP;
          end else begin
            tx_line_nxt = tx_sh_r[0];
            tx_sh_nxt   = {1'b0, tx_sh_r[8:1]};
            tx_idx_nxt  = tx_idx_r + 4'h1;
          end
        end
      end
      ASPR_STOP: begin
        if (tx_baud) begin
          tx_st_nxt = ASPR_IDLE;
        end
      end
      default: tx_st_nxt = ASPR_IDLE;
    endcase
  end

  // transmit registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_r   <= ASPR_IDLE;
      tx_sh_r   <= 9'h000;
      tx_idx_r  <= 4'h0;
      tx_line_r <= 1'b1;
    end else begin
      tx_st_r   <= tx_st_nxt;
      tx_sh_r   <= tx_sh_nxt;
      tx_idx_r  <= tx_idx_nxt;
      tx_line_r <= tx_line_nxt;
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  // receive sequencer: start check, data bits, stop and accept
  always_comb begin
    rx_st_nxt  = rx_st_r;
    rx_sh_nxt  = rx_sh_r;
    rx_idx_nxt = rx_idx_r;
    rx_load    = 1'b0;
    case (rx_st_r)
      ASPR_IDLE: begin
        if (ctrl_r.ren && rx_fall) begin
          rx_st_nxt = ASPR_START;
        end
      end
      ASPR_START: begin
        if (rx_mid) begin
          // false start returns to idle
          rx_st_nxt  = rx_sync_r[1] ? ASPR_IDLE : ASPR_DATA;
          rx_idx_nxt = 4'h0;
        end
      end
      ASPR_DATA: begin
        if (rx_mid) begin
          rx_sh_nxt  = {rx_sync_r[1], rx_sh_r[8:1]};
          rx_idx_nxt = rx_idx_r + 4'h1;
          if (rx_idx_r + 4'h1 == aspr_nbits(ctrl_r.mode)) begin
            rx_st_nxt = ASPR_STOP;
          end
        end
      end
      ASPR_STOP: begin
        if (rx_mid) begin
          rx_st_nxt = ASPR_IDLE;
          if (!ctrl_r.ri) begin
            if (ctrl_r.mode) begin
              rx_load = !ctrl_r.mce || rx_sh_r[8];
            end else begin
              rx_load = !ctrl_r.mce || rx_sync_r[1];
            end
          end
        end
      end
      default: rx_st_nxt = ASPR_IDLE;
    endcase
    // receiver off drops a frame in flight
    if (!ctrl_r.ren) begin
      rx_st_nxt = ASPR_IDLE;
      rx_load   = 1'b0;
    end
  end

  // receive registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_st_r   <= ASPR_IDLE;
      rx_sh_r   <= 9'h000;
      rx_idx_r  <= 4'h0;
    end else begin
      rx_st_r   <= rx_st_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_idx_r  <= rx_idx_nxt;
    end
  end

  // ---------------------------------------------------------------
  // receive line synchroniser
  // ---------------------------------------------------------------
  // second stage alone feeds the edge detector and the sampler
  always_comb begin
    rx_sync_nxt = {rx_sync_r[0], rx_line};
    rx_prev_nxt = rx_sync_r[1];
  end

  // two flops before any logic reads the pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_sync_r <= ASPR_SYNC_INIT;
      rx_prev_r <= 1'b1;
    end else begin
      rx_sync_r <= rx_sync_nxt;
      rx_prev_r <= rx_prev_nxt;
    end
  end

  // ---------------------------------------------------------------
  // control register, receive buffer and read port
  // ---------------------------------------------------------------
  // flag updates, frame store and read mux
  always_comb begin
    ctrl_nxt   = ctrl_r;
    rx_buf_nxt = rx_buf_r;
    rdata_nxt  = rdata_r;
    if (wr_ctrl) begin
      ctrl_nxt.mode = reg_wdata[ASPR_BIT_MODE];
      ctrl_nxt.mce  = reg_wdata[ASPR_BIT_MCE];
      ctrl_nxt.ren  = reg_wdata[ASPR_BIT_REN];
      ctrl_nxt.tb8  = reg_wdata[ASPR_BIT_TB8];
      ctrl_nxt.rb8  = reg_wdata[ASPR_BIT_RB8];
      ctrl_nxt.ti   = reg_wdata[ASPR_BIT_TI];
      ctrl_nxt.ri   = reg_wdata[ASPR_BIT_RI];
    end
    if (tx_st_r == ASPR_DATA && tx_baud &&
        tx_idx_r == aspr_nbits(ctrl_r.mode)) begin
      ctrl_nxt.ti = 1'b1;
    end
    if (rx_load) begin
      rx_buf_nxt   = ctrl_r.mode ? rx_sh_r[7:0] : rx_sh_r[8:1];
      ctrl_nxt.rb8 = ctrl_r.mode ? rx_sh_r[8] : rx_sync_r[1];
      ctrl_nxt.ri  = 1'b1;
    end
    // the transmit shifter is never visible on a read
    // window reads receive buffer
    if (reg_rd && reg_addr == ASPR_DATA_ADDR) begin
      rdata_nxt = rx_buf_r;
    end else if (reg_rd && reg_addr == ASPR_CTRL_ADDR) begin
      rdata_nxt = {ctrl_r.mode, 1'b1, ctrl_r.mce, ctrl_r.ren,
                   ctrl_r.tb8, ctrl_r.rb8, ctrl_r.ti, ctrl_r.ri};
    end else if (reg_rd) begin
      rdata_nxt = 8'h00;
    end
  end

  // control, buffer and read data registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r   <= aspr_ctrl_t'(7'h00);
      rx_buf_r <= 8'h00;
      rdata_r  <= 8'h00;
    end else begin
      ctrl_r   <= ctrl_nxt;
      rx_buf_r <= rx_buf_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  // flags stay, drive request
  assign irq_nxt = irq_enable && (ctrl_nxt.ti || ctrl_nxt.ri);

  // request is registered from the next flag values, so it changes in the same cycle as the flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata        = rdata_r;
  assign irq_req          = irq_r;
  assign tx_line          = tx_line_r;
  assign baud_low_counter = tx_cnt_r;
endmodule : aspr_uart

// *** aspr_uart_sva.sv ***
// checker: port-level assertions for the serial port
module aspr_uart_sva
  import aspr_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       timer_run,
  input wire logic       timer_tick,
  input wire logic [7:0] baud_reload_byte,
  input wire logic       irq_enable,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_req,
  input wire logic       tx_line,
  input wire logic [7:0] baud_low_counter
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // register port and interrupt request
  // ---------------------------------------------------------------
  // unused bit reads one
  chk_bit6_one: assert property (
    reg_rd && reg_addr == ASPR_CTRL_ADDR |=> reg_rdata[ASPR_BIT_UNUSED])
    else $error("control bit 6 read as zero");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr != ASPR_CTRL_ADDR && reg_addr != ASPR_DATA_ADDR
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  chk_irq_off: assert property (
    !irq_enable |=> !irq_req) else $error("irq while disabled");
  chk_irq_cause: assert property (
    $rose(irq_req) |-> $past(irq_enable)) else $error("irq rose unenabled");
  // ---------------------------------------------------------------
  // baud timer and line
  // ---------------------------------------------------------------
  // auto-reload on overflow
  chk_cnt_reload: assert property (
    timer_run && timer_tick && baud_low_counter == 8'hFF
    |=> baud_low_counter == $past(baud_reload_byte))
    else $error("counter missed reload");
  chk_cnt_step: assert property (
    timer_run && timer_tick && baud_low_counter != 8'hFF
    |=> baud_low_counter == $past(baud_low_counter) + 8'h01)
    else $error("counter missed step");
  chk_cnt_hold: assert property (
    !timer_run |=> $stable(baud_low_counter)) else $error("counter ran");
  // each low and each high bit lasts a period
  chk_low_width: assert property (
    $fell(tx_line) && timer_tick && baud_reload_byte == 8'hFC
    |-> !tx_line [*8]) else $error("low bit too short");
  chk_high_width: assert property (
    $rose(tx_line) && timer_tick && baud_reload_byte == 8'hFC
    |-> tx_line [*8]) else $error("high bit too short");
endmodule : aspr_uart_sva

bind aspr_uart aspr_uart_sva aspr_uart_sva_inst (
  .clk_sys(clk_sys), .rst(rst), .timer_run(timer_run),
  .timer_tick(timer_tick), .baud_reload_byte(baud_reload_byte),
  .irq_enable(irq_enable), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq_req(irq_req), .tx_line(tx_line),
  .baud_low_counter(baud_low_counter));

// *** aspr_peer.sv ***
// far-side serial port model driving and sampling the lines
module aspr_peer #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk_sys,
  input  wire logic tx_line,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cap;
  int         got;
  // start on falling edge, sample mid bit
  initial begin
    rx_line = 1'h1;
    got = 0;
    forever begin
      @(negedge tx_line);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 10; i++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        cap[i] = tx_line;
      end
      got++;
    end
  end
  // start, data lsb first, ninth, stop
  task automatic send(input logic [8:0] d9, input logic nine,
                      input logic stp);
    logic [10:0] f;
    f = nine ? {stp, d9, 1'h0} : {1'h1, stp, d9[7:0], 1'h0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clk_sys);
      rx_line <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rx_line <= 1'h1;
    repeat (2 * BIT_CYC) @(posedge clk_sys);
  endtask : send
endmodule : aspr_peer

// *** tb_aspr_uart.sv ***
// testbench: register port and both serial directions
module tb_aspr_uart
  import aspr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic m; logic mce; logic [7:0] d; logic b9; logic stp; logic ld;
  } aspr_row_t;
  logic clk_sys, rst, timer_run, timer_tick, irq_enable, reg_wr, reg_rd;
  logic rx_line, tx_line, irq_req, rb;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, baud_low_counter;
  logic [7:0] baud_reload_byte, last, got8;
  int n_errors = 0, checks = 0, cycles = 0, n;
  aspr_row_t r;
  // mode, check, data, ninth, stop, loaded
  aspr_row_t rows[8] = '{
    '{1'h0, 1'h0, 8'hA5, 1'h0, 1'h1, 1'h1},
    '{1'h0, 1'h0, 8'h3C, 1'h0, 1'h0, 1'h1},
    '{1'h0, 1'h1, 8'h81, 1'h0, 1'h0, 1'h0},
    '{1'h0, 1'h1, 8'h7E, 1'h0, 1'h1, 1'h1},
    '{1'h1, 1'h0, 8'h55, 1'h0, 1'h1, 1'h1},
    '{1'h1, 1'h1, 8'hC3, 1'h0, 1'h1, 1'h0},
    '{1'h1, 1'h1, 8'h96, 1'h1, 1'h0, 1'h1},
    '{1'h1, 1'h0, 8'h0F, 1'h1, 1'h1, 1'h1}};

  aspr_uart aspr_uart_inst (.clk_sys(clk_sys), .rst(rst),
    .timer_run(timer_run), .timer_tick(timer_tick),
    .baud_reload_byte(baud_reload_byte), .irq_enable(irq_enable),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_req(irq_req),
    .tx_line(tx_line), .baud_low_counter(baud_low_counter),
    .rx_line(rx_line));
  aspr_peer #(.BIT_CYC(8)) aspr_peer_inst (.clk_sys(clk_sys),
    .tx_line(tx_line), .rx_line(rx_line));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic xrd(input logic [7:0] a, e, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(negedge clk_sys);
    chk(nm, e, reg_rdata);
  endtask : xrd

  // clock and cycle ceiling
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, timer_run, timer_tick} = 3'h7;
    {irq_enable, reg_wr, reg_rd} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    baud_reload_byte = 8'hFC;
    repeat (6) @(posedge clk_sys);
    chk("reset line", 8'h01, {7'h0, tx_line});
    rst <= 1'h0;
    xrd(ASPR_CTRL_ADDR, ASPR_CTRL_RESET, "ctrl reset");
    wr(ASPR_CTRL_ADDR, 8'h00);
    xrd(ASPR_CTRL_ADDR, 8'h40, "bit6 write");
    xrd(8'h9A, 8'h00, "unmapped");
    @(posedge clk_sys) timer_run <= 1'h0;
    repeat (2) @(negedge clk_sys);
    got8 = baud_low_counter;
    repeat (2) @(negedge clk_sys);
    chk("timer held", got8, baud_low_counter);
    @(posedge clk_sys) timer_run <= 1'h1;
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      wr(ASPR_CTRL_ADDR, {r.m, 1'h0, r.mce, 1'h1, 4'h0});
      aspr_peer_inst.send({r.b9, r.d}, r.m, r.stp);
      rb = r.ld & (r.m ? r.b9 : r.stp);
      if (r.ld) last = r.d;
      xrd(ASPR_CTRL_ADDR, {r.m, 1'h1, r.mce, 2'h2, rb, 1'h0, r.ld},
          "ctrl");
      xrd(ASPR_DATA_ADDR, last, "rx data");
    end
    $display("test receive rows done");
    wr(ASPR_CTRL_ADDR, 8'h10);
    aspr_peer_inst.send(9'h111, 1'h0, 1'h1);
    aspr_peer_inst.send(9'h122, 1'h0, 1'h1);
    xrd(ASPR_DATA_ADDR, 8'h11, "overrun");
    wr(ASPR_CTRL_ADDR, 8'h00);
    aspr_peer_inst.send(9'h1EE, 1'h0, 1'h1);
    xrd(ASPR_CTRL_ADDR, 8'h40, "receiver off");
    xrd(ASPR_DATA_ADDR, 8'h11, "receiver off data");
    $display("test overrun and off done");
    @(posedge clk_sys) irq_enable <= 1'h1;
    for (int m = 0; m < 2; m++) begin
      wr(ASPR_CTRL_ADDR, {m[0], 3'h0, ~m[0], 3'h0});
      n = aspr_peer_inst.got;
      wr(ASPR_DATA_ADDR, 8'hC5);
      for (int k = 0; k < 400 && aspr_peer_inst.got == n; k++)
        @(posedge clk_sys);
      got8 = aspr_peer_inst.cap[7:0];
      chk("tx data", 8'hC5, got8);
      chk("tx tail", {6'h0, 1'h1, ~m[0]},
          {6'h0, aspr_peer_inst.cap[9:8]});
      xrd(ASPR_CTRL_ADDR, {m[0], 3'h4, ~m[0], 3'h2}, "tx done");
      chk("irq on", 8'h01, {7'h0, irq_req});
    end
    wr(ASPR_CTRL_ADDR, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("irq off", 8'h00, {7'h0, irq_req});
    $display("test transmit done");
    complete_run();
  end
endmodule : tb_aspr_uart
